// File: sas_defines.svh
// constants of the conversion sequencer: clock rates, address, widths, resets
// assumes inclusion by bare name from every file that needs a figure
`ifndef SAS_DEFINES_SVH
`define SAS_DEFINES_SVH

// system clock and internal conversion oscillator, in kHz
`define SAS_CLK_FREQ_KHZ 250000
`define SAS_OSC_FREQ_KHZ 4000
// system cycles per conversion step (62.5 rounds down to 62)
`define SAS_OSC_DIV (`SAS_CLK_FREQ_KHZ / `SAS_OSC_FREQ_KHZ)
`define SAS_OSC_CNT_W 6

// fixed upper three bits of the 7-bit bus address
`define SAS_ADDR_FIXED 3'h3
// bits per bus byte before the acknowledge slot
`define SAS_BYTE_BITS 4'h8
// bus clock falls counted in the sampling window, minus one
`define SAS_TRACK_LAST 1'h1
// first trial weight and reset value of the code registers
`define SAS_SAR_MSB 16'h8000
`define SAS_SAR_LSB 16'h0001
`define SAS_CODE_RST 16'h0000
// window on mclk cycles from conversion entry to the clock line release
`define SAS_CONV_CYC_MIN 11'h3E0
`define SAS_CONV_CYC_MAX 11'h3E4

`endif

// File: sas_pkg.sv
// types shared by the conversion sequencer
// assumes nothing beyond a SystemVerilog compiler
package sas_pkg;

    typedef enum logic [2:0] {
        SAS_IDLE  = 3'h0,
        SAS_ADDR  = 3'h1,
        SAS_ACK   = 3'h2,
        SAS_TRACK = 3'h3,
        SAS_CONV  = 3'h4,
        SAS_TX    = 3'h5
    } sas_state_t;

endpackage : sas_pkg

// File: sas_tick_div.sv
// one-cycle enable pulse every DIV cycles while run is high
// assumes run stays high for the whole interval it times
module sas_tick_div #(
    parameter int DIV = 62,
    parameter int W = 6
) (
    // system
    input wire logic mclk,
    input wire logic sys_rst,
    // control
    input wire logic run,
    output logic tick
);

    logic [W-1:0] cnt_q;

    // restart on every run so the first step is a full period away
    always_ff @(posedge mclk) begin
        if (sys_rst || !run) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else if (cnt_q == W'(DIV - 1)) begin
            cnt_q <= '0;
            tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            tick <= 1'b0;
        end
    end

endmodule : sas_tick_div

// File: sas_conv_seq.sv
// conversion sequencer: 2-wire bus slave that samples, converts and returns
// a 16-bit code. bus pins are taken as synchronous to mclk.
// What this block does
// - power-on reset leaves converter core powered down
// - sampling window is two bus clocks before conversion
// - hold by default, track only in window
// - bit decisions timed by internal 4MHz oscillator
// - hold bus clock low during whole conversion
// - keep result stored; master reads after release
// - one 16-bit unipolar code per conversion
// - successive approximation, one bit per decision
// - trim pin at supply selects external reference
// - address is 011 plus four select pins
// - acknowledge own address, then start sampling
// - result sent high byte first, then low
// - keep converting while master acknowledges; nack ends
`include "sas_defines.svh"
module sas_conv_seq (
    // system
    input wire logic mclk,
    input wire logic sys_rst,
    // 2-wire bus, open drain
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // straps
    input wire logic addr_select_pin_0,
    input wire logic addr_select_pin_1,
    input wire logic addr_select_pin_2,
    input wire logic addr_select_pin_3,
    input wire logic bandgap_trim_pin,
    // analog core
    input wire logic comp_in,
    output logic [15:0] dac_code,
    output logic track_en,
    output logic core_pwr_on,
    output logic int_ref_en
);

    sas_pkg::sas_state_t state_q;
    logic scl_q, sda_q;
    logic [3:0] bit_cnt_q;
    logic [6:0] sh_q;
    logic ack_done_q, byte_q, trk_cnt_q;
    logic [15:0] mask_q, result_q, tx_q;
    logic osc_tick;
    logic scl_rise, scl_fall, bus_start, bus_stop, addr_hit, conv_done;
    logic [10:0] conv_len_q;

    assign scl_rise = scl_in && !scl_q;
    assign scl_fall = !scl_in && scl_q;
    assign bus_start = scl_in && scl_q && sda_q && !sda_in;
    assign bus_stop = scl_in && scl_q && !sda_q && sda_in;
    assign addr_hit = (sh_q == {`SAS_ADDR_FIXED, addr_select_pin_3, addr_select_pin_2,
                                addr_select_pin_1, addr_select_pin_0});
    assign conv_done = (state_q == sas_pkg::SAS_CONV) && osc_tick
                       && (mask_q == `SAS_SAR_LSB);
    // both lines only ever pull low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;

    sas_tick_div #(.DIV(`SAS_OSC_DIV), .W(`SAS_OSC_CNT_W)) u_osc (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .run(state_q == sas_pkg::SAS_CONV),
        .tick(osc_tick)
    );

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    // sequence state; start and stop override everything but a conversion,
    // during which the clock line is held low so neither can be seen
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_q <= sas_pkg::SAS_IDLE;
        end else if (bus_start) begin
            state_q <= sas_pkg::SAS_ADDR;
        end else if (bus_stop) begin
            state_q <= sas_pkg::SAS_IDLE;
        end else begin
            case (state_q)
                sas_pkg::SAS_ADDR: begin
                    if (scl_rise && bit_cnt_q == `SAS_BYTE_BITS - 4'h1) begin
                        state_q <= addr_hit ? sas_pkg::SAS_ACK : sas_pkg::SAS_IDLE;
                    end
                end
                sas_pkg::SAS_ACK: begin
                    if (scl_fall && ack_done_q) begin
                        state_q <= sas_pkg::SAS_TRACK;
                    end
                end
                sas_pkg::SAS_TRACK: begin
                    if (scl_fall && trk_cnt_q == `SAS_TRACK_LAST) begin
                        state_q <= sas_pkg::SAS_CONV;
                    end
                end
                sas_pkg::SAS_CONV: begin
                    if (conv_done) begin
                        state_q <= sas_pkg::SAS_TX;
                    end
                end
                sas_pkg::SAS_TX: begin
                    if (scl_rise && bit_cnt_q == `SAS_BYTE_BITS) begin
                        if (sda_in) begin
                            state_q <= sas_pkg::SAS_IDLE;
                        end else if (byte_q) begin
                            state_q <= sas_pkg::SAS_ACK;
                        end
                    end
                end
                default: begin
                    state_q <= state_q;
                end
            endcase
        end
    end

    // bit counting, address shift and the small phase flags
    always_ff @(posedge mclk) begin
        if (sys_rst || bus_start || bus_stop) begin
            bit_cnt_q <= 4'h0;
            sh_q <= 7'h00;
            ack_done_q <= 1'b0;
            byte_q <= 1'b0;
            trk_cnt_q <= 1'b0;
        end else if (state_q == sas_pkg::SAS_ADDR && scl_rise) begin
            sh_q <= {sh_q[5:0], sda_in};
            bit_cnt_q <= bit_cnt_q + 4'h1;
        end else if (state_q == sas_pkg::SAS_ACK && scl_fall) begin
            ack_done_q <= 1'b1;
            trk_cnt_q <= 1'b0;
        end else if (state_q == sas_pkg::SAS_TRACK && scl_fall) begin
            trk_cnt_q <= trk_cnt_q + 1'b1;
        end else if (conv_done) begin
            bit_cnt_q <= 4'h0;
            byte_q <= 1'b0;
        end else if (state_q == sas_pkg::SAS_TX && scl_rise) begin
            if (bit_cnt_q == `SAS_BYTE_BITS) begin
                bit_cnt_q <= 4'h0;
                byte_q <= 1'b1;
                ack_done_q <= byte_q;
            end else begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
            end
        end
    end

    // successive approximation: keep or drop the trial bit on each step
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            dac_code <= `SAS_CODE_RST;
            mask_q <= `SAS_CODE_RST;
            result_q <= `SAS_CODE_RST;
        end else if (state_q == sas_pkg::SAS_TRACK && scl_fall && trk_cnt_q == `SAS_TRACK_LAST) begin
            dac_code <= `SAS_SAR_MSB;
            mask_q <= `SAS_SAR_MSB;
        end else if (state_q == sas_pkg::SAS_CONV && osc_tick) begin
            dac_code <= (comp_in ? dac_code : (dac_code & ~mask_q)) | (mask_q >> 1);
            mask_q <= mask_q >> 1;
            if (mask_q == `SAS_SAR_LSB) begin
                result_q <= comp_in ? dac_code : (dac_code & ~mask_q);
            end
        end
    end

    // output shifter, loaded from the same decision that fills the store
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            tx_q <= `SAS_CODE_RST;
        end else if (conv_done) begin
            tx_q <= comp_in ? dac_code : (dac_code & ~mask_q);
        end else if (state_q == sas_pkg::SAS_TX && scl_rise && bit_cnt_q != `SAS_BYTE_BITS) begin
            tx_q <= {tx_q[14:0], 1'b0};
        end
    end

    // line drivers and analog controls, all from flip-flops
    always_ff @(posedge mclk) begin
        if (sys_rst || bus_start || bus_stop) begin
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
            track_en <= 1'b0;
            core_pwr_on <= 1'b0;
        end else begin
            case (state_q)
                sas_pkg::SAS_ACK: begin
                    if (scl_fall) begin
                        sda_oe <= !ack_done_q;
                        track_en <= ack_done_q;
                        core_pwr_on <= ack_done_q;
                    end
                end
                sas_pkg::SAS_TRACK: begin
                    if (scl_fall && trk_cnt_q == `SAS_TRACK_LAST) begin
                        track_en <= 1'b0;
                        scl_oe <= 1'b1;
                    end
                end
                sas_pkg::SAS_CONV: begin
                    if (conv_done) begin
                        scl_oe <= 1'b0;
                        core_pwr_on <= 1'b0;
                        sda_oe <= !(comp_in ? dac_code[15] : (dac_code[15] & ~mask_q[15]));
                    end
                end
                sas_pkg::SAS_TX: begin
                    if (scl_fall) begin
                        sda_oe <= (bit_cnt_q != `SAS_BYTE_BITS) && !tx_q[15];
                    end else if (scl_rise && bit_cnt_q == `SAS_BYTE_BITS && sda_in) begin
                        sda_oe <= 1'b0;
                    end
                end
                default: begin
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    // cycles spent converting; only the length check reads it
    always_ff @(posedge mclk) begin
        if (sys_rst || state_q != sas_pkg::SAS_CONV) begin
            conv_len_q <= 11'h000;
        end else begin
            conv_len_q <= conv_len_q + 11'h001;
        end
    end

    // reference select follows the trim strap
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            int_ref_en <= 1'b0;
        end else begin
            int_ref_en <= !bandgap_trim_pin;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence s_conv_end;
        (state_q == sas_pkg::SAS_CONV) ##1 (state_q == sas_pkg::SAS_TX);
    endsequence

    sequence s_addr_taken;
        (state_q == sas_pkg::SAS_ADDR) && scl_rise && bit_cnt_q == 4'h7 && addr_hit && !bus_start
            && !bus_stop;
    endsequence

    a_pwr_after_reset: assert property ($fell(sys_rst) |-> !core_pwr_on && !track_en)
        else $error("core not powered down after reset");
    a_window_two_falls: assert property ($fell(track_en) |-> $past(trk_cnt_q) == 1'b1
        && $past(scl_fall) && state_q == sas_pkg::SAS_CONV)
        else $error("sampling window not two bus clocks");
    a_hold_in_conv: assert property (state_q == sas_pkg::SAS_CONV |-> !track_en)
        else $error("tracking during conversion");
    a_step_on_tick: assert property (state_q == sas_pkg::SAS_CONV
        && $past(state_q == sas_pkg::SAS_CONV) && $changed(mask_q) |-> $past(osc_tick))
        else $error("bit decision without oscillator step");
    a_stretch_conv: assert property (state_q == sas_pkg::SAS_CONV |-> scl_oe && !scl_out)
        else $error("clock line not held during conversion");
    a_conv_length: assert property (s_conv_end |-> conv_len_q >= `SAS_CONV_CYC_MIN
        && conv_len_q <= `SAS_CONV_CYC_MAX)
        else $error("conversion length wrong");
    a_latch_release: assert property (s_conv_end |-> !scl_oe && result_q == tx_q
        && sda_oe == !result_q[15])
        else $error("code not latched at clock release");
    a_pwr_down: assert property (s_conv_end |-> !core_pwr_on)
        else $error("core left powered after conversion");
    a_addr_ack: assert property (s_addr_taken |=> state_q == sas_pkg::SAS_ACK)
        else $error("own address not taken");
    a_ack_drive: assert property (state_q == sas_pkg::SAS_ACK && scl_fall && !ack_done_q
        |=> sda_oe)
        else $error("own address not acknowledged");
    a_ref_strap: assert property (bandgap_trim_pin ##1 bandgap_trim_pin |-> !int_ref_en)
        else $error("internal reference on in external mode");
    a_nack_ends: assert property (state_q == sas_pkg::SAS_TX && scl_rise
        && bit_cnt_q == 4'h8 && sda_in && !bus_start && !bus_stop
        |=> state_q == sas_pkg::SAS_IDLE && !sda_oe)
        else $error("nack did not end the read");

endmodule : sas_conv_seq

// File: sas_bus_master.sv
// 2-wire bus master model: open-drain lines with pull-ups, bit-level tasks
// assumes the device only drives pull-down enables; released lines read high
module sas_bus_master #(
    parameter int H = 74
) (
    // system
    input wire logic mclk,
    // device pull-downs
    input wire logic scl_oe,
    input wire logic sda_oe,
    // resolved line levels
    output logic scl_line,
    output logic sda_line
);
    timeunit 1ns;
    timeprecision 1ps;
    logic m_scl = 1'b1;
    logic m_sda = 1'b1;
    logic to_hit = 1'b0;
    int stretch = 0;
    // pull-ups win unless some party pulls low
    assign scl_line = m_scl & ~scl_oe;
    assign sda_line = m_sda & ~sda_oe;

    task automatic wait_h(input int n);
        repeat (n) @(negedge mclk);
    endtask : wait_h

    // half period of H cycles keeps the bus at or below 1.7 MHz
    task automatic bit_xfer(input logic b, output logic r);
        int n;
        n = 0;
        m_scl = 1'b0;
        wait_h(H / 2);
        m_sda = b;
        wait_h(H / 2);
        m_scl = 1'b1;
        // slave may stretch the low phase; give up after a bound
        while (scl_line !== 1'b1 && n < 4000) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 4000) to_hit = 1'b1;
        if (n > stretch) stretch = n;
        wait_h(H / 2);
        r = sda_line;
        wait_h(H / 2);
    endtask : bit_xfer

    task automatic start_c;
        m_sda = 1'b1;
        m_scl = 1'b1;
        wait_h(H);
        m_sda = 1'b0;
        wait_h(H);
    endtask : start_c

    task automatic stop_c;
        m_scl = 1'b0;
        wait_h(H / 2);
        m_sda = 1'b0;
        wait_h(H / 2);
        m_scl = 1'b1;
        wait_h(H);
        m_sda = 1'b1;
        wait_h(H);
    endtask : stop_c

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
        bit_xfer(1'b1, ack);
    endtask : wr_byte

    task automatic rd_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
        // ack pulls sda low and asks for more; nack ends the sequence
        bit_xfer(~ack, r);
    endtask : rd_byte
endmodule : sas_bus_master

// File: sas_conv_seq_tb_top.sv
// self-checking bench for the conversion sequencer
// assumes sas_defines.svh, sas_pkg.sv and the design files are compiled first
`include "sas_defines.svh"
module sas_conv_seq_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int H = 74;
    localparam int NOM = 16 * `SAS_OSC_DIV - H;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] pins = 4'h0;
    logic trim = 1'b0;
    logic comp_in = 1'b0;
    logic [15:0] vin = 16'h0000;
    logic scl_line, sda_line, scl_oe, sda_oe, scl_d;
    logic scl_o, sda_o;
    logic [15:0] dac_code;
    logic track_en, core_pwr_on, int_ref_en;
    int trk_falls = 0;
    int viol = 0;
    int n_mismatch = 0;
    int cmp_count = 0;

    always #2 mclk = ~mclk;

    sas_conv_seq sas_conv_seq_i (
        .mclk(mclk), .sys_rst(sys_rst),
        .scl_in(scl_line), .scl_out(scl_o), .scl_oe(scl_oe),
        .sda_in(sda_line), .sda_out(sda_o), .sda_oe(sda_oe),
        .addr_select_pin_0(pins[0]), .addr_select_pin_1(pins[1]),
        .addr_select_pin_2(pins[2]), .addr_select_pin_3(pins[3]),
        .bandgap_trim_pin(trim), .comp_in(comp_in), .dac_code(dac_code),
        .track_en(track_en), .core_pwr_on(core_pwr_on), .int_ref_en(int_ref_en)
    );

    sas_bus_master #(.H(H)) sas_bus_master_i (
        .mclk(mclk), .scl_oe(scl_oe), .sda_oe(sda_oe),
        .scl_line(scl_line), .sda_line(sda_line)
    );

    // ideal comparator: keep the trial bit while the input is at or above it
    always @(negedge mclk) comp_in <= (vin >= dac_code);

    always @(posedge mclk) begin
        scl_d <= scl_line;
        if (scl_d && !scl_line && track_en) trk_falls <= trk_falls + 1;
        if (scl_oe && (track_en || !core_pwr_on)) viol <= viol + 1;
    end

    always @(posedge sas_bus_master_i.to_hit) begin
        n_mismatch++;
        print_verdict();
    end

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    task automatic t_reset;
        chk("core_pwr_on", 16'h0, core_pwr_on);
        chk("track_en", 16'h0, track_en);
        chk("scl_oe", 16'h0, scl_oe);
        chk("sda_oe", 16'h0, sda_oe);
        chk("scl_out", 16'h0, scl_o);
        chk("sda_out", 16'h0, sda_o);
    endtask : t_reset

    task automatic t_trim;
        for (int t = 0; t < 2; t++) begin
            trim = t[0];
            repeat (3) @(negedge mclk);
            chk("int_ref_en", {15'h0, ~t[0]}, int_ref_en);
        end
    endtask : t_trim

    task automatic t_wrong_addr;
        logic ack;
        pins = 4'hA;
        sas_bus_master_i.start_c();
        sas_bus_master_i.wr_byte({3'h3, 4'h5, 1'b1}, ack);
        chk("ack_low_bits", 16'h1, ack);
        sas_bus_master_i.stop_c();
        sas_bus_master_i.start_c();
        sas_bus_master_i.wr_byte({3'h2, 4'hA, 1'b1}, ack);
        chk("ack_high_bits", 16'h1, ack);
        chk("core_off", 16'h0, core_pwr_on);
        sas_bus_master_i.stop_c();
    endtask : t_wrong_addr

    // two sampling clocks, stretched first data bit, then both result bytes
    task automatic conv_read(input logic [15:0] v, input logic more);
        logic r;
        logic [7:0] hi;
        logic [7:0] lo;
        int f0;
        vin = v;
        sas_bus_master_i.stretch = 0;
        f0 = trk_falls;
        sas_bus_master_i.bit_xfer(1'b1, r);
        sas_bus_master_i.bit_xfer(1'b1, r);
        sas_bus_master_i.rd_byte(1'b1, hi);
        sas_bus_master_i.rd_byte(more, lo);
        chk("result_high", v[15:8], hi);
        chk("result_low", v[7:0], lo);
        chk("track_falls", 16'h2, 16'(trk_falls - f0));
        chk("stretch_ok", 16'h1,
            sas_bus_master_i.stretch >= NOM - 4 && sas_bus_master_i.stretch <= NOM + 8);
        chk("core_off_after", 16'h0, core_pwr_on);
    endtask : conv_read

    task automatic t_convert;
        logic ack;
        pins = 4'h6;
        sas_bus_master_i.start_c();
        sas_bus_master_i.wr_byte({3'h3, 4'h6, 1'b1}, ack);
        chk("addr_ack", 16'h0, ack);
        conv_read(16'hA5C3, 1'b1);
        conv_read(16'hFFFF, 1'b1);
        conv_read(16'h0001, 1'b0);
        chk("sda_after_nack", 16'h0, sda_oe);
        sas_bus_master_i.stop_c();
        chk("hold_in_stretch", 16'h0, viol);
    endtask : t_convert

    initial begin
        repeat (12) @(negedge mclk);
        sys_rst = 1'b0;
        @(negedge mclk);
        t_reset();
        t_trim();
        t_wrong_addr();
        t_convert();
        print_verdict();
    end
endmodule : sas_conv_seq_tb_top
